//--- rtl/pbg_port_b_gpio.sv
/*
  pbg_port_b_gpio: eight-bit port b with direction, output latch, pull-up
  control and interrupt-on-change on the high pins, behind axi4-lite.
  assumes pins are asynchronous to clk; pad buffers and pull-up resistors
  sit outside and follow pinOut, pinOe and pullupEn.
*/
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
// Summary of operation
// R1 - eight pins, each input or output
// R2 - direction one tristates, zero drives latch
// R3 - port read gives pins, write loads latch
// R4 - latch register reads and writes latch
// R5 - cleared pull-up bit enables all pull-ups
// R6 - output pins never get pull-up; pin three driven by capture two still gets one if its direction bit is set
// R7 - second control resets to all ones
// R8 - direction resets to all ones, inputs
// R9 - software sets direction for external interrupts
// R10 - only input high pins are compared
// R11 - mismatch against snapshot sets change flag
// R12 - persisting mismatch keeps setting flag
// R13 - port access refreshes snapshot, except move
// R14 - change interrupt wakes device from sleep
// R15 - software avoids polling port during detection
// R16 - pin three carries alternate capture two
// R17 - low-voltage programming takes pin five
// R18 - pin five pull-up off under programming
// R19 - pin zero feeds pwm fault input
// R20 - enabled flag requests interrupt, priority routed
// R21 - pins synchronised before comparison
`timescale 1ns/1ps
module pbg_port_b_gpio
  import pbg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] pullupEn,
  input wire logic cap2Out,
  input wire logic cap2Oe,
  output logic cap2In,
  output logic pwmFaultIn,
  output logic [3:0] extIrqIn,
  output logic progEnableIn,
  output logic changeIrqHigh,
  output logic changeIrqLow,
  output logic wakeRequest
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic [7:0] outputLatch;
  logic [7:0] direction;
  logic [7:0] intMain;
  logic [7:0] intSecond;
  logic [7:0] intThird;
  logic [7:0] cfgReg;
  logic [3:0] snapshot;
  logic [4:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic haveAw;
  logic haveW;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // two stages; only pinSync is read by logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end else begin
      pinMeta <= pinIn; // R21
      pinSync <= pinMeta; // R21
    end
  end

  // ----------------------------------------
  // pin function muxing
  // ----------------------------------------
  wire lvpOn = cfgReg[PBG_BIT_CFG_LVP];
  wire cap2OnPin = cfgReg[PBG_BIT_CFG_LARGE] && cfgReg[PBG_BIT_CFG_NOT_MCU] &&
    !cfgReg[PBG_BIT_CFG_CAP2SEL];
  wire [7:0] pinOeGpio = ~direction; // R2
  wire [7:0] lvpMask = lvpOn ? (8'h01 << PBG_PIN_PROG) : 8'h00;
  wire [7:0] cap2Mask = cap2OnPin ? (8'h01 << PBG_PIN_CAP2) : 8'h00;
  wire [7:0] portLevels = pinSync & ~lvpMask; // R17

  // pin five is forced to an input while programming is enabled
  assign pinOe = (pinOeGpio & ~lvpMask & ~cap2Mask) | (cap2Oe ? cap2Mask : 8'h00); // R2 R17
  assign pinOut = (outputLatch & ~cap2Mask) | (cap2Out ? cap2Mask : 8'h00); // R1 R16
  // pull-up only on pins whose direction bit is set, never on the programming pin
  assign pullupEn = {8{~intSecond[PBG_BIT_PULLUP_DIS_N]}} & direction & ~lvpMask; // R5 R6 R18
  assign cap2In = cap2OnPin & pinSync[PBG_PIN_CAP2]; // R16
  assign pwmFaultIn = pinSync[PBG_PIN_FAULT]; // R19
  assign extIrqIn = pinSync[3:0] & direction[3:0]; // R9
  assign progEnableIn = lvpOn & pinSync[PBG_PIN_PROG]; // R17

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  wire [3:0] changeMismatch = (pinSync[7:4] ^ snapshot) & direction[7:4]; // R10 R11
  wire changeAny = |changeMismatch; // R11
  wire changeReq = intMain[PBG_BIT_CHANGE_FLAG] & intMain[PBG_BIT_CHANGE_ENABLE];
  assign changeIrqHigh = changeReq & intSecond[PBG_BIT_CHANGE_PRIO]; // R20
  assign changeIrqLow = changeReq & ~intSecond[PBG_BIT_CHANGE_PRIO]; // R20
  // wake needs no enable so sleep exits on any change
  assign wakeRequest = intMain[PBG_BIT_CHANGE_FLAG]; // R14

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  wire wrFire = haveAw && haveW && !bvalid;
  assign awready = !haveAw;
  assign wready = !haveW;
  wire wrHit = wrAddr == PBG_OFF_PIN_LEVELS || wrAddr == PBG_OFF_LATCH ||
    wrAddr == PBG_OFF_DIR || wrAddr == PBG_OFF_INTCTL_MAIN ||
    wrAddr == PBG_OFF_INTCTL_SECOND || wrAddr == PBG_OFF_INTCTL_THIRD ||
    wrAddr == PBG_OFF_CONFIG;
  wire wrLow = wrFire && wrStrb[0];
  wire [7:0] wb = wrData[7:0];
  wire wrPort = wrLow && wrAddr == PBG_OFF_PIN_LEVELS;
  wire rdFire = arvalid && arready;
  wire rdPort = rdFire && araddr == PBG_OFF_PIN_LEVELS;
  // raw move path leaves the snapshot alone
  wire portTouch = (wrPort || rdPort) && !cfgReg[PBG_BIT_CFG_RAW_MOVE]; // R13

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      wrAddr <= 5'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= PBG_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        haveAw <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        haveW <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrFire) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? PBG_RESP_OKAY : PBG_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // flag set beats software clear in the same cycle
  wire flagClear = wrLow && wrAddr == PBG_OFF_INTCTL_MAIN && !wb[PBG_BIT_CHANGE_FLAG];
  wire next_flag = changeAny ? 1'b1 : (flagClear ? 1'b0 : intMain[PBG_BIT_CHANGE_FLAG]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outputLatch <= PBG_RST_LATCH;
      direction <= PBG_RST_DIR; // R8
      intMain <= PBG_RST_INTCTL_MAIN;
      intSecond <= PBG_RST_INTCTL_SECOND; // R7
      intThird <= PBG_RST_INTCTL_THIRD;
      cfgReg <= PBG_RST_CONFIG;
      snapshot <= 4'h0;
    end else begin
      if (wrLow && (wrAddr == PBG_OFF_PIN_LEVELS || wrAddr == PBG_OFF_LATCH)) begin
        outputLatch <= wb; // R3 R4
      end
      if (wrLow && wrAddr == PBG_OFF_DIR) begin
        direction <= wb; // R1
      end
      if (wrLow && wrAddr == PBG_OFF_INTCTL_SECOND) begin
        intSecond <= wb; // R5
      end
      if (wrLow && wrAddr == PBG_OFF_INTCTL_THIRD) begin
        intThird <= wb;
      end
      if (wrLow && wrAddr == PBG_OFF_CONFIG) begin
        cfgReg <= wb;
      end
      if (wrLow && wrAddr == PBG_OFF_INTCTL_MAIN) begin
        intMain[7:1] <= wb[7:1];
      end
      intMain[PBG_BIT_CHANGE_FLAG] <= next_flag; // R12
      if (portTouch) begin
        snapshot <= pinSync[7:4]; // R13
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign arready = !rvalid;
  logic [7:0] rdByte;
  logic rdHit;
  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    unique case (araddr)
      PBG_OFF_PIN_LEVELS: rdByte = portLevels; // R3
      PBG_OFF_LATCH: rdByte = outputLatch; // R4
      PBG_OFF_DIR: rdByte = direction;
      PBG_OFF_INTCTL_MAIN: rdByte = intMain;
      PBG_OFF_INTCTL_SECOND: rdByte = intSecond;
      PBG_OFF_INTCTL_THIRD: rdByte = intThird;
      PBG_OFF_CONFIG: rdByte = cfgReg;
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= PBG_RESP_OKAY;
    end else if (rdFire) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rdByte};
      rresp <= rdHit ? PBG_RESP_OKAY : PBG_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // pbg_port_b_gpio

//--- rtl/pbg_pkg.sv
/*
  pbg_pkg: register map, field positions and reset values of the
  port b gpio block. assumes a 32-bit axi4-lite slave, one word per register.
*/
package pbg_pkg;
  localparam int PBG_WIDTH = 8;
  localparam int PBG_ADDR_W = 5;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] PBG_OFF_PIN_LEVELS = 5'h00;
  localparam logic [4:0] PBG_OFF_LATCH = 5'h04;
  localparam logic [4:0] PBG_OFF_DIR = 5'h08;
  localparam logic [4:0] PBG_OFF_INTCTL_MAIN = 5'h0c;
  localparam logic [4:0] PBG_OFF_INTCTL_SECOND = 5'h10;
  localparam logic [4:0] PBG_OFF_INTCTL_THIRD = 5'h14;
  localparam logic [4:0] PBG_OFF_CONFIG = 5'h18;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PBG_BIT_CHANGE_FLAG = 0;
  localparam int PBG_BIT_CHANGE_ENABLE = 3;
  localparam int PBG_BIT_PULLUP_DIS_N = 7;
  localparam int PBG_BIT_CHANGE_PRIO = 0;
  localparam int PBG_BIT_CFG_LVP = 0;
  localparam int PBG_BIT_CFG_CAP2SEL = 1;
  localparam int PBG_BIT_CFG_NOT_MCU = 2;
  localparam int PBG_BIT_CFG_LARGE = 3;
  localparam int PBG_BIT_CFG_RAW_MOVE = 4;
  localparam int PBG_PIN_CAP2 = 3;
  localparam int PBG_PIN_PROG = 5;
  localparam int PBG_PIN_FAULT = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] PBG_RST_DIR = 8'hff;
  localparam logic [7:0] PBG_RST_INTCTL_SECOND = 8'hff;
  localparam logic [7:0] PBG_RST_INTCTL_THIRD = 8'hc0;
  localparam logic [7:0] PBG_RST_INTCTL_MAIN = 8'h00;
  localparam logic [7:0] PBG_RST_LATCH = 8'h00;
  localparam logic [7:0] PBG_RST_CONFIG = 8'h0a;
  localparam logic [1:0] PBG_RESP_OKAY = 2'b00;
  localparam logic [1:0] PBG_RESP_SLVERR = 2'b10;
endpackage

//--- dv/pbg_pin_world.sv
/*
  pbg_pin_world: board side of port b, signal sources and keypad switches.
  assumes extEn marks the pins that the board drives.
*/
`timescale 1ns/1ps
module pbg_pin_world (
  input wire logic clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupEn,
  input wire logic [7:0] extDrv,
  input wire logic [7:0] extEn,
  output logic [7:0] pinIn
);
  // undriven pins wander, so a stale level never reads as valid
  logic [7:0] floatPat = 8'h55;
  always @(posedge clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extDrv[i];
      else if (pullupEn[i]) pinIn[i] = 1'b1;
      else pinIn[i] = floatPat[i];
    end
  end
endmodule // pbg_pin_world

//--- dv/pbg_port_b_gpio_props.sv
/*
  pbg_port_b_gpio_props: port-level checks of the gpio top.
  assumes one clk domain and async active-low arst_n.
*/
`timescale 1ns/1ps
module pbg_port_b_gpio_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupEn,
  input wire logic [3:0] extIrqIn,
  input wire logic progEnableIn,
  input wire logic changeIrqHigh,
  input wire logic changeIrqLow,
  input wire logic wakeRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pull_off_out: assert property ((pullupEn & pinOe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_safe: assert property ($rose(arst_n) |-> pinOe == 8'h00 && pullupEn == 8'h00)
    else $error("pins not idle after reset");
  a_wake_follows: assert property (changeIrqHigh || changeIrqLow |-> wakeRequest)
    else $error("request without wake");
  a_irq_route: assert property (!(changeIrqHigh && changeIrqLow))
    else $error("change request on both lines");
  a_ext_gate: assert property ((extIrqIn[2:0] & pinOe[2:0]) == 3'b000)
    else $error("external interrupt from output pin");
  a_prog_pin: assert property (progEnableIn |-> !pinOe[5] && !pullupEn[5])
    else $error("programming pin still general");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule // pbg_port_b_gpio_props

bind pbg_port_b_gpio pbg_port_b_gpio_props u_props (.clk(clk), .arst_n(arst_n),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .pinOe(pinOe), .pullupEn(pullupEn), .extIrqIn(extIrqIn), .progEnableIn(progEnableIn),
  .changeIrqHigh(changeIrqHigh), .changeIrqLow(changeIrqLow), .wakeRequest(wakeRequest));

//--- dv/test_port_b_gpio_change_irq.sv
/*
  test_port_b_gpio_change_irq: random and corner checks of port b over axi4-lite.
  assumes pbg_pin_world stands for the board; one clk domain.
*/
`timescale 1ns/1ps
module test_port_b_gpio_change_irq;
  import pbg_pkg::*;
  logic clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic cap2Out = 0, cap2Oe = 0, awready, wready, bvalid, arready, rvalid;
  logic cap2In, pwmFaultIn, progEnableIn, changeIrqHigh, changeIrqLow, wakeRequest;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf, extIrqIn;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] pinIn, pinOut, pinOe, pullupEn, extDrv = 0, extEn = 8'hff, rv, lat, dir, pu;
  int n_mismatch = 0, checked = 0, cyc = 0, seed = 48962;
  always #5 clk = ~clk;
  pbg_port_b_gpio u_dut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn), .cap2Out(cap2Out),
    .cap2Oe(cap2Oe), .cap2In(cap2In), .pwmFaultIn(pwmFaultIn), .extIrqIn(extIrqIn),
    .progEnableIn(progEnableIn), .changeIrqHigh(changeIrqHigh), .changeIrqLow(changeIrqLow),
    .wakeRequest(wakeRequest));
  pbg_pin_world u_world (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .extDrv(extDrv), .extEn(extEn), .pinIn(pinIn));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] exp_port(logic [7:0] l, logic [7:0] d, logic [7:0] e);
    return (l & ~d) | (e & d);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (awvalid || wvalid || !done) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      done = done | bvalid;
    end
    bready <= 0;
  endtask
  // rready comes late on purpose, so the slave must hold its answer
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      rready <= !arvalid;
    end while (!(rvalid && rready));
    d = rdata[7:0];
    r = rresp;
    rready <= 0;
  endtask
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1;
    chk({pinOe, pullupEn}, 16'h0000);
    rd(PBG_OFF_DIR, rv, rr);
    chk(rv, 8'hff);
    rd(PBG_OFF_INTCTL_SECOND, rv, rr);
    chk(rv, 8'hff);
    for (int k = 0; k < 20; k++) begin
      lat = $random(seed);
      dir = $random(seed);
      pu = $random(seed);
      extDrv <= $random(seed);
      wr(k[0] ? PBG_OFF_LATCH : PBG_OFF_PIN_LEVELS, lat);
      wr(PBG_OFF_DIR, dir);
      wr(PBG_OFF_INTCTL_SECOND, pu);
      rd(PBG_OFF_LATCH, rv, rr);
      chk(rv, lat);
      chk({pinOe, pinOut}, {~dir, lat});
      chk(pullupEn, pu[7] ? 8'h00 : dir);
      repeat (3) @(posedge clk);
      rd(PBG_OFF_PIN_LEVELS, rv, rr);
      chk(rv, exp_port(lat, dir, extDrv));
      chk(pwmFaultIn, exp_port(lat, dir, extDrv) & 8'h01);
      chk(extIrqIn, exp_port(lat, dir, extDrv) & dir & 8'h0f);
    end
    extEn <= 8'h00;
    wr(PBG_OFF_DIR, 8'hff);
    wr(PBG_OFF_INTCTL_SECOND, 8'h7f);
    repeat (3) @(posedge clk);
    rd(PBG_OFF_PIN_LEVELS, rv, rr);
    chk(rv, 8'hff);
    wr(PBG_OFF_CONFIG, 8'h0b);
    chk(pullupEn, 8'hdf);
    wr(PBG_OFF_DIR, 8'h00);
    chk({pinOe, pullupEn}, 16'hdf00);
    wr(PBG_OFF_CONFIG, 8'h0a);
    extEn <= 8'hff;
    extDrv <= 8'h00;
    wr(PBG_OFF_DIR, 8'hff);
    wr(PBG_OFF_INTCTL_SECOND, 8'hff);
    repeat (3) @(posedge clk);
    rd(PBG_OFF_PIN_LEVELS, rv, rr);
    wr(PBG_OFF_INTCTL_MAIN, 8'h08);
    chk(wakeRequest, 1'b0);
    extDrv <= 8'h40;
    repeat (4) @(posedge clk);
    chk({wakeRequest, changeIrqHigh, changeIrqLow}, 3'b110);
    wr(PBG_OFF_INTCTL_MAIN, 8'h08);
    chk(wakeRequest, 1'b1);
    rd(PBG_OFF_PIN_LEVELS, rv, rr);
    wr(PBG_OFF_INTCTL_MAIN, 8'h08);
    chk(wakeRequest, 1'b0);
    wr(PBG_OFF_LATCH, 8'h00);
    wr(PBG_OFF_DIR, 8'h7f);
    rd(PBG_OFF_PIN_LEVELS, rv, rr);
    wr(PBG_OFF_INTCTL_MAIN, 8'h08);
    wr(PBG_OFF_LATCH, 8'h80);
    repeat (4) @(posedge clk);
    chk(wakeRequest, 1'b0);
    cap2Oe <= 1;
    cap2Out <= 1;
    wr(PBG_OFF_CONFIG, 8'h0c);
    chk({pinOe[3], pinOut[3]}, 2'b11);
    repeat (3) @(posedge clk);
    chk(cap2In, 1'b1);
    wr(PBG_OFF_CONFIG, 8'h1a);
    extDrv <= 8'h00;
    repeat (4) @(posedge clk);
    rd(PBG_OFF_PIN_LEVELS, rv, rr);
    wr(PBG_OFF_INTCTL_MAIN, 8'h08);
    chk(wakeRequest, 1'b1);
    wr(PBG_OFF_INTCTL_SECOND, 8'hfe);
    chk({changeIrqHigh, changeIrqLow}, 2'b01);
    wr(PBG_OFF_INTCTL_MAIN, 8'h00);
    chk({wakeRequest, changeIrqLow}, 2'b10);
    rd(5'h1c, rv, rr);
    chk({rr, rv}, {PBG_RESP_SLVERR, 8'h00});
    test_done;
  end
endmodule // test_port_b_gpio_change_irq
